// File: cdp_pkg.sv
// Shared constants and types of the count and divide processor
package cdp_pkg;

  // ***********************************************************
  // Scaler and gate geometry
  // ***********************************************************
  localparam int NUM_DECADES = 13;
  localparam int PRESCALE = 20;
  localparam int PRE_W = 5;
  localparam int DIGIT_W = 4;
  localparam int SEL_W = 4;
  localparam int SEL_LINES = 16;
  localparam int ADDR_W = 16;
  localparam logic [DIGIT_W-1:0] GATE_END_DIGIT = 4'h5;
  localparam logic [DIGIT_W-1:0] DIGIT_MAX = 4'h9;
  localparam logic [DIGIT_W-1:0] DIGIT_ZERO = 4'h0;
  localparam logic [PRE_W-1:0] PRE_LAST = 5'h13;

  // ***********************************************************
  // Arithmetic widths
  // ***********************************************************
  localparam int REG_W = 48;
  localparam int REM_W = 52;
  localparam int CNT_W = 4;

  // ***********************************************************
  // Command and qualifier carriers
  // ***********************************************************
  typedef enum logic [3:0] {
    CDP_OP_NOP        = 4'b0000,
    CDP_OP_LOAD_TIME  = 4'b0001,
    CDP_OP_LOAD_EVENT = 4'b0010,
    CDP_OP_DOUBLE     = 4'b0011,
    CDP_OP_EXCHANGE   = 4'b0100,
    CDP_OP_DIVIDE     = 4'b0101,
    CDP_OP_SET_TARGET = 4'b0110,
    CDP_OP_SET_MULT   = 4'b0111,
    CDP_OP_PLUGIN_DP  = 4'b1000,
    CDP_OP_CLR_PLUGIN = 4'b1001
  } cdp_op_t;

  typedef struct packed {
    logic valid;
    cdp_op_t op;
    logic [CNT_W-1:0] arg;
  } cdp_cmd_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic gate_open;
    logic gate_elapsed;
    logic digits_equal;
    logic div_by_zero;
  } cdp_qual_t;

endpackage

// File: cdp_count_divide.sv
// Gated decade scalers, readout and successive-subtraction divider
// Behaviour
// - Gate arms on sample run-down or reset, opens on next input cycle.
// - While gate open, event and time pulses are prescaled by twenty.
// - Scalers are chains of thirteen cascaded decade stages.
// - Scalers accumulate only while the main gate is open.
// - Four-line gate time code decodes to sixteen one-hot lines.
// - Monitored time decade showing five ends gate on next Channel A pulse.
// - Decades read out as BCD digits addressed by 16-bit counter.
// - Time count is doubled by adding it to itself.
// - Event count goes to divisor, doubled time stays in dividend.
// - Gate-time measurements always compute dividend over divisor.
// - Frequency swaps dividend and divisor first; period does not.
// - Swap goes through a holding latch, one register at a time.
// - Divide by repeated subtraction, counting each successful subtraction.
// - Finished digit moves to quotient register; next digit follows.
// - Division ends when progress counter equals requested digit count.
// - Final quotient is copied into the divisor register for output.
// - Result point counter tracks the quotient's decimal point.
// - Plug-in point counter tracks decimal point from the plug-in.
// - Multiplier store holds the unit multiplier of the result.
`timescale 1ns/1ps
module cdp_count_divide
  import cdp_pkg::*;
#(
  parameter int N_DEC = NUM_DECADES
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Pulse inputs from the input channels (asynchronous)
  input wire logic i_event_pin,
  input wire logic i_time_pin,
  input wire logic i_chan_a_pin,
  // Measurement set-up from the sequencer
  input wire logic i_arm_rundown,
  input wire logic [SEL_W-1:0] i_gate_sel,
  input wire logic i_freq_mode,
  input wire cdp_cmd_t i_cmd,
  // Results and qualifiers
  output cdp_qual_t o_qual,
  output logic [DIGIT_W-1:0] o_readout_digit,
  output logic [ADDR_W-1:0] o_readout_addr,
  output logic [REG_W-1:0] o_dividend,
  output logic [REG_W-1:0] o_divisor,
  output logic [CNT_W-1:0] o_result_point,
  output logic [CNT_W-1:0] o_plugin_point,
  output logic [CNT_W-1:0] o_multiplier
);

  // ***********************************************************
  // Functions
  // ***********************************************************
  // Pick one decade digit from a flattened scaler
  function automatic logic [DIGIT_W-1:0] pick_digit(
    input logic [N_DEC*DIGIT_W-1:0] flat,
    input logic [ADDR_W-1:0] idx
  );
    pick_digit = DIGIT_ZERO;
    for (int k = 0; k < N_DEC; k++) begin
      if (idx == ADDR_W'(k)) begin
        pick_digit = flat[k*DIGIT_W +: DIGIT_W];
      end
    end
  endfunction

  // Multiply by ten with shifts, truncated to the given width
  function automatic logic [REM_W-1:0] times_ten(input logic [REM_W-1:0] v);
    times_ten = (v << 3) + (v << 1);
  endfunction

  // ***********************************************************
  // Input synchronisers
  // ***********************************************************
  logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic ev_edge, tm_edge, ca_edge;

  // Two flops per pin; the third only remembers the last level
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 3'h0;
    end else begin
      pin_s1_q <= {i_chan_a_pin, i_time_pin, i_event_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign ev_edge = pin_s2_q[0] & ~pin_s3_q[0];
  assign tm_edge = pin_s2_q[1] & ~pin_s3_q[1];
  assign ca_edge = pin_s2_q[2] & ~pin_s3_q[2];

  // ***********************************************************
  // Main gate
  // ***********************************************************
  logic armed_q, gate_q, elapsed_q;
  logic [SEL_LINES-1:0] gate_onehot;
  logic mon_five;
  logic [N_DEC*DIGIT_W-1:0] ev_flat, tm_flat;

  assign gate_onehot = SEL_LINES'(1) << i_gate_sel;
  // Codes above the last decade never end the gate; the sequencer
  // must not select them
  always_comb begin
    mon_five = 1'b0;
    for (int k = 0; k < N_DEC; k++) begin
      if (gate_onehot[k] && tm_flat[k*DIGIT_W +: DIGIT_W] == GATE_END_DIGIT) begin
        mon_five = 1'b1;
      end
    end
  end

  // Arm, open on next input cycle, close on Channel A after elapse
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      armed_q <= 1'b1;
      gate_q <= 1'b0;
      elapsed_q <= 1'b0;
    end else if (i_arm_rundown) begin
      armed_q <= 1'b1;
      gate_q <= 1'b0;
      elapsed_q <= 1'b0;
    end else begin
      if (armed_q && ev_edge) begin
        armed_q <= 1'b0;
        gate_q <= 1'b1;
      end
      if (gate_q && mon_five) begin
        elapsed_q <= 1'b1;
      end
      if (gate_q && (elapsed_q || mon_five) && ca_edge) begin
        gate_q <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // Prescalers and decade chains
  // ***********************************************************
  logic [PRE_W-1:0] ev_pre_q, tm_pre_q;
  logic ev_tc, tm_tc;
  logic [N_DEC:0] ev_inc, tm_inc;

  assign ev_tc = gate_q && ev_edge && ev_pre_q == PRE_LAST;
  assign tm_tc = gate_q && tm_edge && tm_pre_q == PRE_LAST;

  // Divide-by-twenty front stage; cleared when a new gate is armed
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || i_arm_rundown) begin
      ev_pre_q <= '0;
      tm_pre_q <= '0;
    end else if (gate_q) begin
      if (ev_edge) begin
        ev_pre_q <= ev_tc ? '0 : ev_pre_q + PRE_W'(1);
      end
      if (tm_edge) begin
        tm_pre_q <= tm_tc ? '0 : tm_pre_q + PRE_W'(1);
      end
    end
  end

  assign ev_inc[0] = ev_tc;
  assign tm_inc[0] = tm_tc;

  // Thirteen decades per scaler, carry rippling on a nine
  for (genvar g = 0; g < N_DEC; g++) begin : g_decade
    logic [DIGIT_W-1:0] ev_dig_q, tm_dig_q;
    assign ev_inc[g+1] = ev_inc[g] && ev_dig_q == DIGIT_MAX;
    assign tm_inc[g+1] = tm_inc[g] && tm_dig_q == DIGIT_MAX;
    assign ev_flat[g*DIGIT_W +: DIGIT_W] = ev_dig_q;
    assign tm_flat[g*DIGIT_W +: DIGIT_W] = tm_dig_q;
    always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || i_arm_rundown) begin
        ev_dig_q <= DIGIT_ZERO;
        tm_dig_q <= DIGIT_ZERO;
      end else begin
        if (ev_inc[g]) begin
          ev_dig_q <= ev_inc[g+1] ? DIGIT_ZERO : ev_dig_q + 4'h1;
        end
        if (tm_inc[g]) begin
          tm_dig_q <= tm_inc[g+1] ? DIGIT_ZERO : tm_dig_q + 4'h1;
        end
      end
    end
  end

  // ***********************************************************
  // Processing sequencer
  // ***********************************************************
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_READ  = 4'b0001,
    ST_XA    = 4'b0010,
    ST_XB    = 4'b0011,
    ST_XC    = 4'b0100,
    ST_NORM  = 4'b0101,
    ST_SUB   = 4'b0110,
    ST_NEXT  = 4'b0111,
    ST_STORE = 4'b1000
  } cdp_state_t;

  cdp_state_t state_q;
  logic read_time_q, done_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DIGIT_W-1:0] rd_digit;
  logic [REG_W-1:0] dividend_register_q, divisor_register_q;
  logic [REG_W-1:0] latch_q, quotient_q;
  logic [REM_W-1:0] rem_q, work_q, work_x10, rem_x10;
  logic [CNT_W-1:0] qdigit_q, digit_progress_counter_q;
  logic [CNT_W-1:0] digit_target_store_q, result_point_counter_q;
  logic [CNT_W-1:0] plugin_point_q, mult_store_q;
  logic cmd_go, dig_eq;

  assign cmd_go = i_cmd.valid && state_q == ST_IDLE;
  assign rd_digit = pick_digit(read_time_q ? tm_flat : ev_flat, addr_q);
  assign work_x10 = times_ten(work_q);
  assign rem_x10 = times_ten(rem_q);
  assign dig_eq = digit_progress_counter_q == digit_target_store_q;

  // Step control and readout address counter
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      addr_q <= '0;
      read_time_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cmd_go) begin
            case (i_cmd.op)
              CDP_OP_LOAD_TIME, CDP_OP_LOAD_EVENT: begin
                read_time_q <= i_cmd.op == CDP_OP_LOAD_TIME;
                addr_q <= ADDR_W'(N_DEC - 1);
                state_q <= ST_READ;
              end
              CDP_OP_EXCHANGE: begin
                // Period mode leaves the operands in place
                if (i_freq_mode) begin
                  state_q <= ST_XA;
                end else begin
                  done_q <= 1'b1;
                end
              end
              CDP_OP_DIVIDE: begin
                state_q <= divisor_register_q == '0 ? ST_STORE : ST_NORM;
              end
              default: begin
                done_q <= 1'b1;
              end
            endcase
          end
        end
        ST_READ: begin
          addr_q <= addr_q - ADDR_W'(1);
          if (addr_q == '0) begin
            state_q <= ST_IDLE;
            done_q <= 1'b1;
          end
        end
        ST_XA: state_q <= ST_XB;
        ST_XB: state_q <= ST_XC;
        ST_XC: begin
          state_q <= ST_IDLE;
          done_q <= 1'b1;
        end
        ST_NORM: begin
          if (work_x10 > rem_q) begin
            state_q <= ST_SUB;
          end
        end
        ST_SUB: begin
          if (rem_q < work_q) begin
            state_q <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          state_q <= (digit_progress_counter_q + CNT_W'(1) ==
                      digit_target_store_q) ? ST_STORE : ST_SUB;
        end
        ST_STORE: begin
          state_q <= ST_IDLE;
          done_q <= 1'b1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Operand registers, holding latch and quotient register
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      dividend_register_q <= '0;
      divisor_register_q <= '0;
      latch_q <= '0;
      quotient_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_go && i_cmd.op == CDP_OP_LOAD_TIME) begin
            dividend_register_q <= '0;
          end
          if (cmd_go && i_cmd.op == CDP_OP_LOAD_EVENT) begin
            divisor_register_q <= '0;
          end
          if (cmd_go && i_cmd.op == CDP_OP_DOUBLE) begin
            dividend_register_q <= dividend_register_q +
                                   dividend_register_q;
          end
          if (cmd_go && i_cmd.op == CDP_OP_DIVIDE) begin
            quotient_q <= '0;
          end
        end
        ST_READ: begin
          // Most significant decade first, accumulated in binary
          if (read_time_q) begin
            dividend_register_q <= REG_W'(times_ten(REM_W'(dividend_register_q))
                                   + REM_W'(rd_digit));
          end else begin
            divisor_register_q <= REG_W'(times_ten(REM_W'(divisor_register_q))
                                  + REM_W'(rd_digit));
          end
        end
        ST_XA: latch_q <= dividend_register_q;
        ST_XB: dividend_register_q <= divisor_register_q;
        ST_XC: divisor_register_q <= latch_q;
        ST_NEXT: begin
          quotient_q <= REG_W'(times_ten(REM_W'(quotient_q))
                        + REM_W'(qdigit_q));
        end
        ST_STORE: divisor_register_q <= quotient_q;
        default: ;
      endcase
    end
  end

  // Remainder, scaled divisor and the per-digit subtraction count
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rem_q <= '0;
      work_q <= '0;
      qdigit_q <= '0;
      digit_progress_counter_q <= '0;
      result_point_counter_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_go && i_cmd.op == CDP_OP_DIVIDE) begin
            rem_q <= REM_W'(dividend_register_q);
            work_q <= REM_W'(divisor_register_q);
            qdigit_q <= '0;
            digit_progress_counter_q <= '0;
            result_point_counter_q <= '0;
          end
        end
        ST_NORM: begin
          // Align divisor so the first digit is non-zero unless divisor exceeds dividend
          if (work_x10 <= rem_q) begin
            work_q <= work_x10;
            result_point_counter_q <= result_point_counter_q +
                                      CNT_W'(1);
          end
        end
        ST_SUB: begin
          if (rem_q >= work_q) begin
            rem_q <= rem_q - work_q;
            qdigit_q <= qdigit_q + CNT_W'(1);
          end
        end
        ST_NEXT: begin
          rem_q <= rem_x10;
          qdigit_q <= '0;
          digit_progress_counter_q <= digit_progress_counter_q +
                                      CNT_W'(1);
        end
        default: ;
      endcase
    end
  end

  // Digit target, plug-in point and unit multiplier stores
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      digit_target_store_q <= '0;
      plugin_point_q <= '0;
      mult_store_q <= '0;
    end else if (cmd_go) begin
      case (i_cmd.op)
        CDP_OP_SET_TARGET: digit_target_store_q <= i_cmd.arg;
        CDP_OP_SET_MULT: mult_store_q <= i_cmd.arg;
        CDP_OP_PLUGIN_DP: plugin_point_q <= plugin_point_q +
                                            CNT_W'(1);
        CDP_OP_CLR_PLUGIN: plugin_point_q <= '0;
        default: ;
      endcase
    end
  end

  // Readout digit is registered so the data lines never glitch
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_readout_digit <= DIGIT_ZERO;
    end else begin
      o_readout_digit <= rd_digit;
    end
  end

  // ***********************************************************
  // Outputs and qualifiers
  // ***********************************************************
  assign o_readout_addr = addr_q;
  assign o_dividend = dividend_register_q;
  assign o_divisor = divisor_register_q;
  assign o_result_point = result_point_counter_q;
  assign o_plugin_point = plugin_point_q;
  assign o_multiplier = mult_store_q;
  assign o_qual.busy = state_q != ST_IDLE;
  assign o_qual.done = done_q;
  assign o_qual.gate_open = gate_q;
  assign o_qual.gate_elapsed = elapsed_q;
  assign o_qual.digits_equal = dig_eq;
  assign o_qual.div_by_zero = divisor_register_q == '0;

endmodule // cdp_count_divide

// File: cdp_count_divide_monitor.sv
// Port-level assertions on the count and divide processor
`timescale 1ns/1ps
module cdp_count_divide_monitor
  import cdp_pkg::*;
#(
  parameter int N_DEC = NUM_DECADES
) (
  // Clock, reset and inputs
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_arm_rundown,
  input wire logic i_freq_mode,
  input wire cdp_cmd_t i_cmd,
  // Outputs watched
  input wire cdp_qual_t o_qual,
  input wire logic [REG_W-1:0] o_dividend,
  input wire logic [REG_W-1:0] o_divisor
);
  // ***********************************************************
  // Operand snapshot at command take
  // ***********************************************************
  logic take;
  logic [REG_W-1:0] nd_q;
  logic [REG_W-1:0] dv_q;
  assign take = i_cmd.valid && !o_qual.busy;
  // Snapshot lets later cycles compare with pre-command values
  always_ff @(posedge i_clk_sys) begin
    if (take) begin
      nd_q <= o_dividend;
      dv_q <= o_divisor;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Thirteen busy cycles while decades are read one by one
  sequence s_read;
    o_qual.busy[*8] ##1 o_qual.busy[*5];
  endsequence
  // Swap ends with each operand in the other register
  sequence s_swap;
    ##[3:5] (o_qual.done && o_dividend == dv_q && o_divisor == nd_q);
  endsequence
  // ***********************************************************
  // Assertions
  // ***********************************************************
  AST_ARM_CLEARS: assert property (
    i_arm_rundown |=> !o_qual.gate_open && !o_qual.gate_elapsed)
    else $error("gate not cleared by arm");
  AST_ELAPSE_OPEN: assert property (
    $rose(o_qual.gate_elapsed) |-> $past(o_qual.gate_open))
    else $error("gate time elapsed with gate closed");
  AST_CLOSE_ELAPSED: assert property (
    $fell(o_qual.gate_open) && !$past(i_arm_rundown)
      |-> ##[0:1] o_qual.gate_elapsed)
    else $error("gate closed before gate time");
  AST_ZERO_FLAG: assert property (
    o_qual.div_by_zero == (o_divisor == '0))
    else $error("zero divisor flag wrong");
  AST_LOAD_READ: assert property (
    take && (i_cmd.op == CDP_OP_LOAD_TIME || i_cmd.op == CDP_OP_LOAD_EVENT)
      |=> s_read ##[1:2] o_qual.done)
    else $error("decade readout length wrong");
  AST_SWAP_FREQ: assert property (
    take && i_cmd.op == CDP_OP_EXCHANGE && i_freq_mode |-> s_swap)
    else $error("frequency exchange wrong");
  AST_SWAP_PERIOD: assert property (
    take && i_cmd.op == CDP_OP_EXCHANGE && !i_freq_mode
      |=> !o_qual.busy && o_dividend == nd_q && o_divisor == dv_q)
    else $error("period exchange altered registers");
  AST_DOUBLE: assert property (
    take && i_cmd.op == CDP_OP_DOUBLE |-> ##[1:2]
      (o_qual.done && o_dividend == {nd_q[REG_W-2:0], 1'b0}))
    else $error("time count not doubled");
  AST_DIV_ZERO: assert property (
    take && i_cmd.op == CDP_OP_DIVIDE && o_qual.div_by_zero
      |-> ##[1:6] (o_qual.done && o_divisor == '0))
    else $error("divide by zero result wrong");
endmodule // cdp_count_divide_monitor

bind cdp_count_divide cdp_count_divide_monitor #(.N_DEC(N_DEC))
  cdp_count_divide_monitor_inst (
  .i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n),
  .i_arm_rundown(i_arm_rundown),
  .i_freq_mode(i_freq_mode),
  .i_cmd(i_cmd),
  .o_qual(o_qual),
  .o_dividend(o_dividend),
  .o_divisor(o_divisor)
);

// File: cdp_seq_model.sv
// Behavioural model of the sequencer that commands the processor
`timescale 1ns/1ps
module cdp_seq_model
  import cdp_pkg::*;
(
  // Clock and qualifiers from the processor
  input wire logic i_clk_sys,
  input wire cdp_qual_t i_qual,
  // Command lines to the processor
  output cdp_cmd_t o_cmd
);
  // Idle cycles before each command; nonzero models a slow sequencer
  int slow = 0;
  // Handshake waits that ran out of cycles; the bench fails on any
  int timeouts = 0;
  initial o_cmd = '0;
  // Step to just after the next rising edge
  task automatic step();
    @(posedge i_clk_sys);
    #2;
  endtask
  // Raise the command, hold it to the take edge, then await done
  task automatic issue(input cdp_op_t op, input logic [CNT_W-1:0] a);
    int i;
    repeat (slow) step();
    o_cmd = '{valid: 1'b1, op: op, arg: a};
    i = 0;
    while (i_qual.busy !== 1'b0 && i < 300) begin
      step();
      i++;
    end
    if (i_qual.busy !== 1'b0) timeouts++;
    step();
    o_cmd.valid = 1'b0;
    i = 0;
    // Qualifier sampled before the next step may start
    while (i_qual.done !== 1'b1 && i < 300) begin
      step();
      i++;
    end
    if (i_qual.done !== 1'b1) timeouts++;
    // One edge passes so valid never drops and rises in one time step
    step();
  endtask
endmodule // cdp_seq_model

// File: tb.sv
// Self-checking testbench of the count and divide processor
`timescale 1ns/1ps
module tb;
  import cdp_pkg::*;
  // ***********************************************************
  // Stimulus, design and partner
  // ***********************************************************
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic [2:0] pins = 3'h0; // Event, time, Channel A
  logic i_arm_rundown = 1'b0;
  logic [SEL_W-1:0] i_gate_sel = 4'h0;
  logic i_freq_mode = 1'b0;
  cdp_cmd_t i_cmd;
  cdp_qual_t o_qual;
  logic [DIGIT_W-1:0] o_readout_digit;
  logic [ADDR_W-1:0] o_readout_addr;
  logic [REG_W-1:0] o_dividend;
  logic [REG_W-1:0] o_divisor;
  logic [CNT_W-1:0] o_result_point;
  logic [CNT_W-1:0] o_plugin_point;
  logic [CNT_W-1:0] o_multiplier;
  int err_count = 0;
  int n_checks = 0;
  // Free-running 20 MHz clock
  initial begin
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  cdp_count_divide cdp_count_divide_inst (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_event_pin(pins[0]),
    .i_time_pin(pins[1]),
    .i_chan_a_pin(pins[2]),
    .i_arm_rundown(i_arm_rundown),
    .i_gate_sel(i_gate_sel),
    .i_freq_mode(i_freq_mode),
    .i_cmd(i_cmd),
    .o_qual(o_qual),
    .o_readout_digit(o_readout_digit),
    .o_readout_addr(o_readout_addr),
    .o_dividend(o_dividend),
    .o_divisor(o_divisor),
    .o_result_point(o_result_point),
    .o_plugin_point(o_plugin_point),
    .o_multiplier(o_multiplier)
  );
  cdp_seq_model cdp_seq_model_inst (
    .i_clk_sys(i_clk_sys),
    .i_qual(o_qual),
    .o_cmd(i_cmd)
  );
  // ***********************************************************
  // Shared tasks
  // ***********************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #2;
  endtask
  task automatic chk(input logic [REG_W-1:0] got, input int exp);
    n_checks++;
    if (got !== REG_W'(exp)) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // A handshake wait that runs out ends the run as a mismatch
  task automatic cmd(input cdp_op_t op, input logic [CNT_W-1:0] a);
    cdp_seq_model_inst.issue(op, a);
    if (cdp_seq_model_inst.timeouts != 0) begin
      err_count++;
      $display("ERROR at %0t: timeouts %h expected %h", $time,
               cdp_seq_model_inst.timeouts, 0);
      report_and_stop();
    end
  endtask
  // Pins stay high 3 and low 4 cycles so the synchronisers see every edge
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      pins[k] = 1'b1;
      tick(3);
      pins[k] = 1'b0;
      tick(4);
    end
  endtask
  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic t_reset();
    chk(REG_W'(o_qual.div_by_zero), 1);
    chk(REG_W'(o_qual.gate_open), 0);
    cmd(CDP_OP_DIVIDE, 4'h0);
    chk(o_divisor, 0);
    $display("test reset finished");
  endtask
  // Time edges while closed must not shorten the gate time
  task automatic t_gate();
    i_arm_rundown = 1'b1;
    tick(1);
    i_arm_rundown = 1'b0;
    pulse(1, 20);
    pulse(0, 1);
    chk(REG_W'(o_qual.gate_open), 1);
    pulse(1, 99);
    chk(REG_W'(o_qual.gate_elapsed), 0);
    pulse(1, 1);
    chk(REG_W'(o_qual.gate_elapsed), 1);
    pulse(0, 40);
    pulse(2, 1);
    chk(REG_W'(o_qual.gate_open), 0);
    pulse(0, 20);
    $display("test gate finished");
  endtask
  // Time count 5 doubles to 10, event count 2; period needs no swap
  task automatic t_period();
    i_freq_mode = 1'b0;
    cmd(CDP_OP_LOAD_TIME, 4'h0);
    cmd(CDP_OP_DOUBLE, 4'h0);
    chk(o_dividend, 10);
    // Decade 0 is addressed last; its digit shows one cycle later
    fork
      cmd(CDP_OP_LOAD_EVENT, 4'h0);
      begin
        tick(13);
        chk(REG_W'(o_readout_addr), 0);
        tick(1);
        chk(REG_W'(o_readout_digit), 2);
      end
    join
    chk(o_divisor, 2);
    cmd(CDP_OP_EXCHANGE, 4'h0);
    chk(o_dividend, 10);
    cmd(CDP_OP_SET_TARGET, 4'h2);
    cmd(CDP_OP_DIVIDE, 4'h0);
    chk(o_divisor, 50);
    chk(REG_W'(o_result_point), 0);
    chk(REG_W'(o_qual.digits_equal), 1);
    $display("test period finished");
  endtask
  // Slow sequencer; swapped operands give 2 / 10 to three digits
  task automatic t_freq();
    cdp_seq_model_inst.slow = 2;
    i_freq_mode = 1'b1;
    cmd(CDP_OP_LOAD_TIME, 4'h0);
    cmd(CDP_OP_DOUBLE, 4'h0);
    cmd(CDP_OP_LOAD_EVENT, 4'h0);
    cmd(CDP_OP_EXCHANGE, 4'h0);
    chk(o_dividend, 2);
    chk(o_divisor, 10);
    cmd(CDP_OP_SET_TARGET, 4'h3);
    cmd(CDP_OP_DIVIDE, 4'h0);
    chk(o_divisor, 20);
    // Swap back to 20 / 2: one alignment step moves the point
    cmd(CDP_OP_EXCHANGE, 4'h0);
    cmd(CDP_OP_DIVIDE, 4'h0);
    chk(o_divisor, 100);
    chk(REG_W'(o_result_point), 1);
    cdp_seq_model_inst.slow = 0;
    $display("test frequency finished");
  endtask
  // Point and multiplier stores, then a reset in mid-run
  task automatic t_misc();
    cmd(CDP_OP_SET_MULT, 4'h6);
    chk(REG_W'(o_multiplier), 6);
    cmd(CDP_OP_PLUGIN_DP, 4'h3);
    chk(REG_W'(o_plugin_point != 4'h0), 1);
    cmd(CDP_OP_CLR_PLUGIN, 4'h0);
    chk(REG_W'(o_plugin_point), 0);
    i_rst_n = 1'b0;
    tick(3);
    i_rst_n = 1'b1;
    tick(1);
    chk(REG_W'(o_multiplier), 0);
    chk(REG_W'(o_qual.gate_open), 0);
    $display("test stores finished");
  endtask
  // ***********************************************************
  // Sequence, watchdog and verdict
  // ***********************************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    tick(20);
    i_rst_n = 1'b1;
    tick(1);
    t_reset();
    t_gate();
    t_period();
    t_freq();
    t_misc();
    report_and_stop();
  end
  // Tests need about 1500 cycles; stop a hang well past that
  initial begin
    tick(6000);
    err_count++;
    $display("ERROR at %0t: watchdog checks %h expected %h", $time,
             n_checks, 0);
    report_and_stop();
  end
endmodule // tb
